/* File: hdl/gioc_pkg.sv */
// package for the general i/o line controller: widths, reset values, line map
// assumes a single master clock domain and 32 lines
package gioc_pkg;
  localparam int          GIOC_LINES        = 32;
  // lines that carry a multiplexed peripheral (1 = multiplexed)
  localparam logic [31:0] GIOC_MUX_LINES    = 32'hffff_ffff;
  // lines that exist in this product
  localparam logic [31:0] GIOC_IMPL_LINES   = 32'hffff_ffff;
  // reset ownership per line, 1 = controller owns the line
  localparam logic [31:0] GIOC_OWN_RST      = 32'hffff_ffff;
  localparam logic [31:0] GIOC_PULLOFF_RST  = 32'h0000_0000;
  localparam logic [31:0] GIOC_CHOICE_RST   = 32'h0000_0000;
  localparam logic [31:0] GIOC_DRIVE_RST    = 32'h0000_0000;
  localparam logic [31:0] GIOC_LEVEL_RST    = 32'h0000_0000;
  localparam logic [31:0] GIOC_WMASK_RST    = 32'h0000_0000;
  localparam logic [31:0] GIOC_ODRAIN_RST   = 32'h0000_0000;
  localparam logic [31:0] GIOC_FILTER_RST   = 32'h0000_0000;
  localparam logic [31:0] GIOC_IRQMASK_RST  = 32'h0000_0000;
  localparam logic [31:0] GIOC_EVENT_RST    = 32'h0000_0000;
  // cycles after reset until a synchroniser chain shows the real pin
  localparam logic [2:0]  GIOC_SYNC_FILL    = 3'h4;
  localparam logic [2:0]  GIOC_WARM_RST     = 3'h0;
  localparam logic [31:0] GIOC_ZERO         = 32'h0000_0000;
endpackage

/* File: hdl/gioc_sync3.sv */
// three-stage input synchroniser with agreement check, one instance per line
// assumes asynchronous pin input and clk of the controller domain
`timescale 1ns/1ps
module gioc_sync3 (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic val;
  } gioc_sync_t;

  gioc_sync_t st_q;
  gioc_sync_t st_d;

  // shift chain; value follows once stages two and three agree
  always_comb begin
    st_d     = st_q;
    st_d.s1  = din;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.val = st_q.s3;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.val;
endmodule

/* File: hdl/gioc_top.sv */
// general i/o line controller: per-line ownership, drive, level, open drain,
// pull-up, glitch filter, pin readback and change detection for 32 lines
// assumes write strobes are one-cycle pulses from logic on clk, pins async
// ctrl_clk_en stands for the controller clock gate; writes act without it
// Notes on behaviour
// - pull-up enable clears, disable sets off-status
// - pull-up writes apply under any configuration
// - reset: all pull-ups on, status zero
// - own enable sets, disable clears ownership
// - unmuxed lines ignore ownership writes, read one
// - ownership reset value is a product constant
// - a-select clears, b-select sets choice bit
// - choice steers outputs only; inputs reach both
// - reset: choice bits zero, peripheral a
// - choice writes apply regardless of ownership
// - peripheral owned line takes peripheral drive
// - drive enable sets, disable clears, any ownership
// - level set/clear work even under peripheral ownership
// - direct level write changes unmasked bits only
// - reset: direct write mask all zero
// - open drain bit set/clear; drives low only
// - pin status shows level, holds while clock off
// - filter rejects half-cycle glitches, passes full cycles
// - filter latency none; the filtered level reaches readback on the same edge as the unfiltered one
// - filter set/clear; acts on readback and detection
// - irq mask set/clear; compare successive samples
// - change sets event; or of masked events; read clears
// - unimplemented line bits ignore writes, read zero
// - interrupt only while controller clock enabled

`timescale 1ns/1ps
module gioc_top
  import gioc_pkg::*;
(
  // clock, reset and controller clock gate
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ctrl_clk_en,
  // set and clear strobes, one bit per line, plus the direct level write and the event status read strobe
  input  wire logic [31:0] pullup_enable_write,
  input  wire logic [31:0] pullup_disable_write,
  input  wire logic [31:0] line_own_enable_write,
  input  wire logic [31:0] line_own_disable_write,
  input  wire logic [31:0] periph_a_select_write,
  input  wire logic [31:0] periph_b_select_write,
  input  wire logic [31:0] drive_enable_write,
  input  wire logic [31:0] drive_disable_write,
  input  wire logic [31:0] level_set_write,
  input  wire logic [31:0] level_clear_write,
  input  wire logic        level_direct_wr,
  input  wire logic [31:0] level_direct_data,
  input  wire logic [31:0] direct_write_unmask,
  input  wire logic [31:0] direct_write_mask,
  input  wire logic [31:0] open_drain_enable_write,
  input  wire logic [31:0] open_drain_disable_write,
  input  wire logic [31:0] filter_enable_write,
  input  wire logic [31:0] filter_disable_write,
  input  wire logic [31:0] change_irq_enable_write,
  input  wire logic [31:0] change_irq_disable_write,
  input  wire logic        event_status_rd,
  // on-chip peripheral drive requests
  input  wire logic [31:0] periph_a_out,
  input  wire logic [31:0] periph_a_oe,
  input  wire logic [31:0] periph_b_out,
  input  wire logic [31:0] periph_b_oe,
  // pins, asynchronous to clk
  input  wire logic [31:0] pin_in,
  // pad and peripheral side outputs
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe,
  output logic      [31:0] pin_pullup_en,
  output logic      [31:0] periph_in,
  // status of every set and clear pair, pin readback and the change interrupt
  output logic      [31:0] pullup_off_status,
  output logic      [31:0] line_ownership_status,
  output logic      [31:0] periph_choice_status,
  output logic      [31:0] drive_status,
  output logic      [31:0] output_level_status,
  output logic      [31:0] direct_write_mask_status,
  output logic      [31:0] open_drain_status,
  output logic      [31:0] filter_status,
  output logic      [31:0] change_irq_mask,
  output logic      [31:0] change_event_status,
  output logic      [31:0] pin_level_status,
  output logic             change_irq
);
  typedef struct packed {
    // configuration bits, one per line
    logic [31:0] pulloff;
    logic [31:0] own;
    logic [31:0] choice;
    logic [31:0] drive;
    logic [31:0] level;
    logic [31:0] wmask;
    logic [31:0] odrain;
    logic [31:0] filter;
    logic [31:0] imask;
    // input path and change detection
    logic [31:0] event_st;
    logic [31:0] filt_hold;
    logic [31:0] prev;
    logic        prev_ok;
    logic [2:0]  warm;
    logic [31:0] pdsr;
    // registered pin and peripheral side
    logic [31:0] pin_o;
    logic [31:0] pin_e;
    logic [31:0] pu_en;
    logic [31:0] p_in;
    logic        irq;
  } gioc_state_t;

  gioc_state_t st_q;
  gioc_state_t st_d;
  logic [31:0] pin_sync;
  logic [31:0] pin_fall_q;

  // one synchroniser per line: four flops keep a metastable pin
  // level away from the filter, readback and change detection
  genvar gi;
  generate
    for (gi = 0; gi < GIOC_LINES; gi++) begin : g_sync
      gioc_sync3 u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  (pin_in[gi]),
        .dout (pin_sync[gi])
      );
    end
  endgenerate

  // falling-edge sample: filter half-cycle stage
  // a level is taken only once both clock edges have seen it
  always_ff @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_fall_q <= GIOC_ZERO;
    end else begin
      pin_fall_q <= pin_sync;
    end
  end

  // next state of every register
  always_comb begin
    logic [31:0] filt;
    logic [31:0] sampled;
    logic [31:0] change;
    logic [31:0] oe_src;
    logic [31:0] o_src;

    filt    = GIOC_ZERO;
    sampled = GIOC_ZERO;
    change  = GIOC_ZERO;
    oe_src  = GIOC_ZERO;
    o_src   = GIOC_ZERO;
    st_d    = st_q;

    // pull-up control under any configuration
    st_d.pulloff = (st_q.pulloff | pullup_disable_write) & ~pullup_enable_write;

    // ownership, only on multiplexed lines
    // lines without a peripheral always read as controller owned
    st_d.own = (st_q.own | line_own_enable_write) & ~line_own_disable_write;
    st_d.own = st_d.own | ~GIOC_MUX_LINES;
    st_d.choice = (st_q.choice | periph_b_select_write) & ~periph_a_select_write;
    st_d.drive  = (st_q.drive | drive_enable_write) & ~drive_disable_write;
    st_d.level  = (st_q.level | level_set_write) & ~level_clear_write;
    if (level_direct_wr) begin
      st_d.level = (st_d.level & ~st_q.wmask) | (level_direct_data & st_q.wmask);
    end
    // direct-write mask, unmask sets and mask clears
    st_d.wmask  = (st_q.wmask | direct_write_unmask) & ~direct_write_mask;
    st_d.odrain = (st_q.odrain | open_drain_enable_write) & ~open_drain_disable_write;
    st_d.filter = (st_q.filter | filter_enable_write) & ~filter_disable_write;
    st_d.imask  = (st_q.imask | change_irq_enable_write) & ~change_irq_disable_write;

    // unimplemented lines keep zero
    st_d.pulloff = st_d.pulloff & GIOC_IMPL_LINES;
    st_d.own     = st_d.own & GIOC_IMPL_LINES;
    st_d.choice  = st_d.choice & GIOC_IMPL_LINES;
    st_d.drive   = st_d.drive & GIOC_IMPL_LINES;
    st_d.level   = st_d.level & GIOC_IMPL_LINES;
    st_d.wmask   = st_d.wmask & GIOC_IMPL_LINES;
    st_d.odrain  = st_d.odrain & GIOC_IMPL_LINES;
    st_d.filter  = st_d.filter & GIOC_IMPL_LINES;
    st_d.imask   = st_d.imask & GIOC_IMPL_LINES;

    // filter: accept a level only when both half-cycle samples agree
    // otherwise the last accepted level is held
    filt = st_q.filt_hold;
    for (int i = 0; i < GIOC_LINES; i++) begin
      if (pin_fall_q[i] == pin_sync[i]) begin
        filt[i] = pin_sync[i];
      end
    end
    st_d.filt_hold = filt;
    // filtered level only where the line's filter is on
    sampled = ((filt & st_q.filter) | (pin_sync & ~st_q.filter)) & GIOC_IMPL_LINES;

    // hold off change detection after reset until the synchronisers
    // show the real pins, so an idle high line gives no false change
    if (st_q.warm != GIOC_SYNC_FILL) begin
      st_d.warm = st_q.warm + 3'h1;
    end

    // readback and change detection only with controller clock on;
    // the first sample after the gate opens only primes the compare
    if (ctrl_clk_en) begin
      st_d.pdsr    = sampled;
      st_d.prev    = sampled;
      st_d.prev_ok = (st_q.warm == GIOC_SYNC_FILL);
      if (st_q.prev_ok) begin
        change = sampled ^ st_q.prev;
      end
    end else begin
      st_d.prev_ok = 1'b0;
    end

    // read clears all, new change wins over the clear
    // so a change landing in the read cycle is never lost
    if (event_status_rd) begin
      st_d.event_st = change;
    end else begin
      st_d.event_st = st_q.event_st | change;
    end
    // one interrupt line, only while the controller clock runs
    st_d.irq = ctrl_clk_en && ((st_d.event_st & st_d.imask) != GIOC_ZERO);

    // output path mux: own registers or chosen peripheral
    // peripheral choice steers drive only, never the input path
    for (int i = 0; i < GIOC_LINES; i++) begin
      if (st_d.own[i]) begin
        o_src[i]  = st_d.level[i];
        oe_src[i] = st_d.drive[i];
      end else if (st_d.choice[i]) begin
        o_src[i]  = periph_b_out[i];
        oe_src[i] = periph_b_oe[i];
      end else begin
        o_src[i]  = periph_a_out[i];
        oe_src[i] = periph_a_oe[i];
      end
    end

    // open drain: drive only when low, so a high level floats to
    // the pull-up and never fights another low driver
    st_d.pin_e = (oe_src & ~(st_d.odrain & o_src)) & GIOC_IMPL_LINES;
    st_d.pin_o = o_src & GIOC_IMPL_LINES;
    st_d.pu_en = ~st_d.pulloff & GIOC_IMPL_LINES;

    // peripherals see the unfiltered pin regardless of choice
    st_d.p_in  = pin_sync;
  end

  // state register with product reset values; every field is named
  // so a new field cannot slip through without a reset value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q.pulloff   <= GIOC_PULLOFF_RST;
      st_q.own       <= GIOC_OWN_RST | ~GIOC_MUX_LINES;
      st_q.choice    <= GIOC_CHOICE_RST;
      st_q.drive     <= GIOC_DRIVE_RST;
      st_q.level     <= GIOC_LEVEL_RST;
      st_q.wmask     <= GIOC_WMASK_RST;
      st_q.odrain    <= GIOC_ODRAIN_RST;
      st_q.filter    <= GIOC_FILTER_RST;
      st_q.imask     <= GIOC_IRQMASK_RST;
      st_q.event_st  <= GIOC_EVENT_RST;
      st_q.filt_hold <= GIOC_ZERO;
      st_q.prev      <= GIOC_ZERO;
      st_q.prev_ok   <= 1'b0;
      st_q.warm      <= GIOC_WARM_RST;
      st_q.pdsr      <= GIOC_ZERO;
      st_q.pin_o     <= GIOC_ZERO;
      st_q.pin_e     <= GIOC_ZERO;
      st_q.p_in      <= GIOC_ZERO;
      st_q.irq       <= 1'b0;
      st_q.pu_en     <= ~GIOC_PULLOFF_RST & GIOC_IMPL_LINES;
    end else begin
      st_q <= st_d;
    end
  end

  // pad and peripheral side outputs straight from the state register
  assign pin_out                  = st_q.pin_o;
  assign pin_oe                   = st_q.pin_e;
  assign pin_pullup_en            = st_q.pu_en;
  assign periph_in                = st_q.p_in;

  // status outputs, one bit per line, and the single change interrupt
  assign pullup_off_status        = st_q.pulloff;
  assign line_ownership_status    = st_q.own;
  assign periph_choice_status     = st_q.choice;
  assign drive_status             = st_q.drive;
  assign output_level_status      = st_q.level;
  assign direct_write_mask_status = st_q.wmask;
  assign open_drain_status        = st_q.odrain;
  assign filter_status            = st_q.filter;
  assign change_irq_mask          = st_q.imask;
  assign change_event_status      = st_q.event_st;
  assign pin_level_status         = st_q.pdsr;
  assign change_irq               = st_q.irq;
endmodule

/* File: verif/gioc_chk.sv */
// checker for gioc_top: status updates, pin drive and change interrupt
// assumes it is bound onto gioc_top, one clk domain
`timescale 1ns/1ps
module gioc_chk
  import gioc_pkg::*;
(
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ctrl_clk_en,
  input wire logic [31:0] pullup_enable_write,
  input wire logic [31:0] pullup_disable_write,
  input wire logic [31:0] line_own_enable_write,
  input wire logic [31:0] line_own_disable_write,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_pullup_en,
  input wire logic [31:0] pullup_off_status,
  input wire logic [31:0] line_ownership_status,
  input wire logic [31:0] drive_status,
  input wire logic [31:0] output_level_status,
  input wire logic [31:0] open_drain_status,
  input wire logic [31:0] change_irq_mask,
  input wire logic [31:0] change_event_status,
  input wire logic [31:0] pin_level_status,
  input wire logic        change_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // gate held off, or on, for two edges
  sequence s_gated;
    !ctrl_clk_en [*2];
  endsequence
  sequence s_live;
    ctrl_clk_en [*2];
  endsequence
  // set and clear pairs, clear wins
  property p_pu;
    pullup_off_status == (($past(pullup_off_status) | $past(pullup_disable_write))
      & ~$past(pullup_enable_write));
  endproperty
  property p_own;
    |line_own_disable_write |=> line_ownership_status == ((($past(line_ownership_status)
      | $past(line_own_enable_write)) & ~$past(line_own_disable_write)) | ~GIOC_MUX_LINES);
  endproperty
  property p_pullen;
    pin_pullup_en == ~pullup_off_status;
  endproperty
  // owned lines: drive bit, dropped while open drain and high
  property p_oe_own;
    (pin_oe & line_ownership_status) == (drive_status & line_ownership_status
      & ~(open_drain_status & output_level_status));
  endproperty
  // interrupt is the or of masked events, only with the clock on
  property p_irq;
    change_irq |-> |(change_event_status & change_irq_mask);
  endproperty
  property p_irq_on;
    s_live ##0 |(change_event_status & change_irq_mask) |-> change_irq;
  endproperty
  property p_irq_gate;
    s_gated |-> !change_irq;
  endproperty
  property p_noev;
    s_gated |-> (change_event_status & ~$past(change_event_status)) == 32'h0;
  endproperty
  property p_frz;
    !ctrl_clk_en |=> $stable(pin_level_status);
  endproperty
  a_pu: assert property (p_pu) else $error("pull-up status wrong");
  a_own: assert property (p_own) else $error("ownership status wrong");
  a_pullen: assert property (p_pullen) else $error("pull-up pin wrong");
  a_oe_own: assert property (p_oe_own) else $error("owned drive wrong");
  a_irq: assert property (p_irq) else $error("irq without event");
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  a_irq_gate: assert property (p_irq_gate) else $error("irq while gated");
  a_noev: assert property (p_noev) else $error("event while gated");
  a_frz: assert property (p_frz) else $error("readback moved while gated");
endmodule
bind gioc_top gioc_chk chk_u (.clk, .nrst, .ctrl_clk_en, .pullup_enable_write,
  .pullup_disable_write, .line_own_enable_write, .line_own_disable_write, .pin_oe,
  .pin_pullup_en, .pullup_off_status, .line_ownership_status, .drive_status,
  .output_level_status, .open_drain_status, .change_irq_mask, .change_event_status,
  .pin_level_status, .change_irq);

/* File: verif/gioc_ext.sv */
// far side of the pins: external drivers, pull-ups and floating lines
// assumes pin_out and pin_oe from gioc_top, ext_drv and ext_lvl from the bench
`timescale 1ns/1ps
module gioc_ext (
  input  wire logic        clk,
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pin_pullup_en,
  input  wire logic [31:0] ext_drv,
  input  wire logic [31:0] ext_lvl,
  output logic      [31:0] pin_in
);
  logic [31:0] flt_q = 32'h0;
  // undriven lines without pull-up flip every cycle
  always @(posedge clk) flt_q <= ~flt_q;
  // controller drive first, then external drive, then pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_lvl)
    | (~pin_oe & ~ext_drv & (pin_pullup_en | flt_q));
endmodule

/* File: verif/tb_gioc_top.sv */
// bench for gioc_top: write pulses, status, pin and interrupt checks
// assumes gioc_ext on the pins and the package default line maps
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_gioc_top;
  import gioc_pkg::*;
  localparam int PUE = 0, PUD = 1, OWE = 2, OWD = 3, PA = 4, PB = 5, DE = 6, DD = 7, LS = 8;
  localparam int LC = 9, WU = 10, WM = 11, ODE = 12, ODD = 13, FE = 14, FD = 15, IE = 16, ID = 17;
  logic        clk = 1'b0, nrst = 1'b0, ctrl_clk_en = 1'b1;
  logic        level_direct_wr = 1'b0, event_status_rd = 1'b0, change_irq;
  logic [31:0] w [18] = '{default: 32'h0};
  logic [31:0] level_direct_data = 32'h0, ext_lvl = 32'h0, ext_drv = 32'hffff_ff00;
  logic [31:0] periph_a_out = 32'h0d00, periph_a_oe = 32'h0f00;
  logic [31:0] periph_b_out = 32'h0200, periph_b_oe = 32'h0f00;
  logic [31:0] pin_in, pin_out, pin_oe, pin_pullup_en, periph_in, pullup_off_status;
  logic [31:0] line_ownership_status, periph_choice_status, drive_status, output_level_status;
  logic [31:0] direct_write_mask_status, open_drain_status, filter_status, change_irq_mask;
  logic [31:0] change_event_status, pin_level_status;
  int          num_errors = 0, checks_done = 0, cyc = 0;
  gioc_top dut_u (.pullup_enable_write(w[PUE]), .pullup_disable_write(w[PUD]),
    .line_own_enable_write(w[OWE]), .line_own_disable_write(w[OWD]),
    .periph_a_select_write(w[PA]), .periph_b_select_write(w[PB]),
    .drive_enable_write(w[DE]), .drive_disable_write(w[DD]), .level_set_write(w[LS]),
    .level_clear_write(w[LC]), .direct_write_unmask(w[WU]), .direct_write_mask(w[WM]),
    .open_drain_enable_write(w[ODE]), .open_drain_disable_write(w[ODD]),
    .filter_enable_write(w[FE]), .filter_disable_write(w[FD]),
    .change_irq_enable_write(w[IE]), .change_irq_disable_write(w[ID]), .*);
  gioc_ext ext_u (.clk, .pin_out, .pin_oe, .pin_pullup_en, .ext_drv, .ext_lvl, .pin_in);
  // clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one-cycle write pulse; status is read once the edge has landed
  task automatic wr(input int i, input logic [31:0] v);
    @(posedge clk) w[i] <= v;
    @(posedge clk) w[i] <= 32'h0;
    #1;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic dw(input logic [31:0] v);
    @(posedge clk) {level_direct_wr, level_direct_data} <= {1'b1, v};
    @(posedge clk) level_direct_wr <= 1'b0;
    #1;
  endtask
  task automatic rd();
    @(posedge clk) event_status_rd <= 1'b1;
    @(posedge clk) event_status_rd <= 1'b0;
    #1;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    #1;
    `CHK("pu rst", 32'h0, pullup_off_status)
    `CHK("choice rst", 32'h0, periph_choice_status)
    `CHK("wmask rst", 32'h0, direct_write_mask_status)
    `CHK("od rst", 32'h0, open_drain_status)
    `CHK("own rst", GIOC_OWN_RST | ~GIOC_MUX_LINES, line_ownership_status)
    wr(PB, 32'h0e00);
    wr(PA, 32'h0400);
    `CHK("choice", 32'h0a00, periph_choice_status)
    wr(OWD, 32'h1f00);
    wr(OWE, 32'h1000);
    `CHK("own", ~32'h0f00, line_ownership_status)
    wr(PUD, 32'h01f0);
    wr(PUE, 32'h0100);
    `CHK("pu", 32'h00f0, pullup_off_status)
    `CHK("pu pin", ~32'h00f0, pin_pullup_en)
    wr(DE, 32'h01ff);
    `CHK("drive on", 32'h01ff, drive_status)
    wr(DD, 32'h0100);
    `CHK("drive off", 32'h00ff, drive_status)
    wr(LS, 32'h010f);
    `CHK("lvl set", 32'h010f, output_level_status)
    wr(LC, 32'h0100);
    dw(32'hffff_ffff);
    `CHK("lvl masked", 32'h000f, output_level_status)
    wr(WU, 32'h00f0);
    dw(32'h0000_00a5);
    `CHK("lvl direct", 32'h00af, output_level_status)
    wr(ODE, 32'h0003);
    `CHK("od", 32'h0000_0003, open_drain_status)
    tick(10);
    `CHK("oe", 32'h0ffc, pin_oe)
    `CHK("out", 32'h07ac, pin_out & 32'h0ffc)
    `CHK("pins", 32'h07af, pin_level_status)
    @(posedge clk) periph_a_oe <= 32'h0;
    tick(10);
    `CHK("oe per", 32'h0afc, pin_oe)
    `CHK("per in", 32'h02af, periph_in)
    `CHK("irq unmasked", 1'b0, change_irq)
    rd();
    `CHK("ev clr", 32'h0, change_event_status)
    wr(FE, 32'h0010_0000);
    `CHK("filt", 32'h0010_0000, filter_status)
    wr(IE, 32'h0030_0000);
    wr(ID, 32'h0020_0000);
    `CHK("mask", 32'h0010_0000, change_irq_mask)
    @(posedge clk) ext_lvl <= 32'h0010_0000;
    for (int k = 0; k < 20 && change_irq !== 1'b1; k++) tick(1);
    `CHK("irq", 1'b1, change_irq)
    `CHK("ev", 32'h0010_0000, change_event_status)
    rd();
    `CHK("irq clr", 1'b0, change_irq)
    @(posedge clk) ctrl_clk_en <= 1'b0;
    tick(2);
    @(posedge clk) ext_lvl <= 32'h0;
    tick(12);
    `CHK("pins held", 32'h0010_02af, pin_level_status)
    `CHK("ev gated", 32'h0, change_event_status)
    @(posedge clk) ctrl_clk_en <= 1'b1;
    tick(12);
    `CHK("pins live", 32'h02af, pin_level_status)
    `CHK("ev primed", 32'h0, change_event_status)
    wr(FD, 32'h0010_0000);
    `CHK("filt off", 32'h0, filter_status)
    end_of_test();
  end
endmodule
